// ---- spr_pkg.sv ----
// Package for the single-port RAM: sizes, modes and port bundles
`default_nettype none
package spr_pkg;
	localparam int unsigned DEPTH      = 16;
	localparam int unsigned DATA_W     = 16;
	localparam int unsigned ADDR_W     = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned INIT_LEN   = 4;
	localparam int unsigned LATENCY    = 1;
	// Fixed-point format of the data port
	localparam bit          DATA_SIGNED = 1'b1;
	localparam int unsigned FRAC_W      = 8;
	// Initial values are given wider, with extra fraction bits, then fitted
	localparam int unsigned INIT_W      = 32;
	localparam int unsigned INIT_FRAC_W = 16;
	localparam logic [INIT_W-1:0] INIT_VEC [INIT_LEN] = '{
		32'h0001_0000, 32'h0000_8000, 32'hffff_4000, 32'h7fff_ffff
	};
	localparam logic [INIT_W-1:0] OUT_PRESET = 32'h0000_0000;

	typedef enum logic [1:0] {
		SPR_READ_BEFORE = 2'b00,
		SPR_READ_AFTER  = 2'b01,
		SPR_NO_READ     = 2'b11
	} spr_mode_e;
	typedef enum logic {
		SPR_BLOCK = 1'b0,
		SPR_DIST  = 1'b1
	} spr_mem_e;
	localparam spr_mode_e WRITE_MODE = SPR_READ_BEFORE;
	localparam spr_mem_e  MEM_TYPE   = SPR_BLOCK;
	localparam bit        OUT_RST_EN = 1'b1;

	typedef logic [DATA_W-1:0] spr_word_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		spr_word_t         wdata;
		logic              we;
	} spr_req_s;

	// Saturate and round-half-up a wide init value into the port format
	function automatic spr_word_t spr_fit(input logic [INIT_W-1:0] v);
		logic signed [INIT_W:0] x;
		logic signed [INIT_W:0] hi;
		logic signed [INIT_W:0] lo;
		x = DATA_SIGNED ? {v[INIT_W-1], v} : {1'b0, v};
		x = x + ((INIT_W+1)'(1) <<< (INIT_FRAC_W - FRAC_W - 1));
		x = x >>> (INIT_FRAC_W - FRAC_W);
		hi = DATA_SIGNED ? (INIT_W+1)'((64'd1 << (DATA_W-1)) - 1)
			: (INIT_W+1)'((64'd1 << DATA_W) - 1);
		lo = DATA_SIGNED ? -(INIT_W+1)'(64'd1 << (DATA_W-1)) : '0;
		if (x > hi)
			x = hi;
		if (x < lo)
			x = lo;
		return x[DATA_W-1:0];
	endfunction
endpackage
`default_nettype wire

// ---- spr_single_port_ram.sv ----
// Single-port word RAM with selectable write mode, memory type and latency
//
// Function
// RQ1: Three inputs address, write data, write enable; one read data output.
// RQ2: All words and both data ports share one fixed-point format.
// RQ3: Driver supplies unsigned addresses from zero to depth minus one.
// RQ4: Write enable high at clock edge stores write data at address.
// RQ5: With write enable low, output shows word at current address.
// RQ6: Depth is a positive word count and sets the address range.
// RQ7: Initial entries beyond depth are ignored.
// RQ8: Words beyond the initial list start at zero.
// RQ9: Initial values are saturated and rounded to the word format.
// RQ10: Read-before mode outputs the old word during a write.
// RQ11: Read-after mode outputs the newly written word.
// RQ12: No-read mode holds the output during a write.
// RQ13: Build option picks block or distributed storage, shaping write behaviour.
// RQ14: Output reset clears only the output register, never stored words.
// RQ15: Output reset is offered only at latency one.
// RQ16: Output register starts at a fitted preset value.
// RQ17: Driver never reads past top address; result there is undefined.
// RQ18: Distributed storage allows read-after mode only with latency above zero.
// RQ19: Inputs sampled on rising edge; data after configured latency.
`default_nettype none
module spr_single_port_ram
	import spr_pkg::*;
(
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              reset,
	input  wire logic              clk_en,
	// Optional output-register reset
	input  wire logic              out_rst,
	// RQ1 RQ2: request in, one word format
	input  wire spr_req_s          req,
	// Read data
	output logic [DATA_W-1:0]      rdata
);
	// RQ6: depth and latency sanity
	localparam int unsigned LAT_W = (LATENCY > 0) ? LATENCY : 1;
	// RQ13: distributed storage is inherently read-before unless patched below
	// RQ18: read-after on distributed storage needs a registered stage
	localparam bit MODE_OK = !(MEM_TYPE == SPR_DIST && WRITE_MODE == SPR_READ_AFTER
		&& LATENCY == 0) && DEPTH > 0;
	// RQ15: reset port only live at latency one
	localparam bit RST_LIVE = OUT_RST_EN && (LATENCY == 1);
	localparam spr_mode_e EFF_MODE = MODE_OK ? WRITE_MODE : SPR_READ_BEFORE;
	// RQ16: fitted preset, a constant for the async reset branch
	localparam spr_word_t PRESET_W = spr_fit(OUT_PRESET);

	spr_word_t mem_reg  [DEPTH];
	spr_word_t mem_next [DEPTH];
	spr_word_t pipe_reg  [LAT_W];
	spr_word_t pipe_next [LAT_W];
	logic      loaded_reg;
	logic      loaded_next;
	spr_word_t hold_reg;
	spr_word_t hold_next;
	spr_word_t read_word;
	spr_word_t stage_in;
	logic      in_range;

	// RQ17: out-of-range reads give no flag, data reads as zero
	assign in_range  = 32'(req.addr) < DEPTH;
	assign read_word = in_range ? mem_reg[req.addr] : '0;

	// RQ10: old word; RQ11: new word; RQ12: previous output held
	always_comb begin
		stage_in = read_word;
		if (req.we) begin
			unique case (EFF_MODE)
				SPR_READ_BEFORE: stage_in = read_word;
				SPR_READ_AFTER:  stage_in = req.wdata;
				SPR_NO_READ:     stage_in = hold_reg;
				default:         stage_in = read_word;
			endcase
		end
	end

	// RQ4: write into addressed word on the edge
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_next[i] = mem_reg[i];
		end
		loaded_next = 1'b1;
		if (!loaded_reg) begin
			// RQ8: words past the list start at zero
			for (int i = 0; i < DEPTH; i++) begin
				mem_next[i] = '0;
			end
			// RQ7: entries past depth are skipped
			for (int i = 0; i < INIT_LEN; i++) begin
				if (i < DEPTH) begin
					// RQ9: fit value to port format
					mem_next[i] = spr_fit(INIT_VEC[i]);
				end
			end
		end else if (req.we && in_range) begin
			mem_next[req.addr] = req.wdata;
		end
	end

	// RQ19: latency pipeline
	always_comb begin
		pipe_next[0] = stage_in;
		for (int i = 1; i < LAT_W; i++) begin
			pipe_next[i] = pipe_reg[i-1];
		end
		// Hold tracks the last value fed in, so no-read repeats it
		hold_next = stage_in;
		// RQ14: only the output register and the hold register clear
		if (RST_LIVE && out_rst) begin
			pipe_next[LAT_W-1] = PRESET_W;
			hold_next          = PRESET_W;
		end
	end

	// Contents load on the first enabled edge after reset release, not from async reset
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			loaded_reg <= 1'b0;
		end else if (clk_en) begin
			loaded_reg <= loaded_next;
		end
	end

	// Storage has no reset so that it maps onto RAM
	always_ff @(posedge ref_clk) begin
		if (clk_en) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= mem_next[i];
			end
		end
	end

	// RQ16: output register starts at preset
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < LAT_W; i++) begin
				pipe_reg[i] <= PRESET_W;
			end
			hold_reg <= PRESET_W;
		end else if (clk_en) begin
			for (int i = 0; i < LAT_W; i++) begin
				pipe_reg[i] <= pipe_next[i];
			end
			hold_reg <= hold_next;
		end
	end

	// RQ5: read path; zero latency is combinational
	assign rdata = (LATENCY == 0) ? stage_in : pipe_reg[LAT_W-1];
endmodule // spr_single_port_ram
`default_nettype wire

// ---- spr_drv.sv ----
// Driving-logic model for the RAM
`default_nettype none
module spr_drv
	import spr_pkg::*;
(
	input  wire logic ref_clk,
	output var logic  clk_en,
	output var logic  out_rst,
	output var spr_req_s req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {clk_en, out_rst, req} = '0;
	task put(input logic [2:0] c, input logic [ADDR_W-1:0] a, input spr_word_t d);
		@(posedge ref_clk);
		#1;
		{clk_en, out_rst, req} <= {c[2], c[1], a, d, c[0]};
	endtask
endmodule // spr_drv
`default_nettype wire

// ---- spr_single_port_ram_assertions.sv ----
// Port assertions for the single-port RAM
`default_nettype none
module spr_single_port_ram_assertions
	import spr_pkg::*;
(
	input wire logic     ref_clk,
	input wire logic     reset,
	input wire logic     clk_en,
	input wire logic     out_rst,
	input wire spr_req_s req,
	input wire logic [DATA_W-1:0] rdata
);
	logic live;
	wire w = live && clk_en && req.we && !out_rst;
	wire r = live && clk_en && !req.we && !out_rst;
	wire [ADDR_W-1:0] a = req.addr;
	// First enabled edge only loads contents
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			live <= 1'b0;
		else if (clk_en)
			live <= 1'b1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	property p_rst; clk_en && out_rst |=> rdata == '0; endproperty
	property p_frz; !clk_en |=> $stable(rdata); endproperty
	property p_wr; w ##1 r && a == $past(a) |=> rdata == $past(req.wdata, 2); endproperty
	property p_old; w ##1 w && a == $past(a) |=> rdata == $past(req.wdata, 2); endproperty
	property p_rd; r ##1 r && $stable(a) |=> rdata == $past(rdata); endproperty
	property p_keep;
		w ##1 clk_en && out_rst ##1 r && a == $past(a, 2) |=> rdata == $past(req.wdata, 3);
	endproperty
	property p_off;
		w ##1 !clk_en ##1 r && a == $past(a, 2) |=> rdata == $past(req.wdata, 3);
	endproperty
	property p_own;
		w ##1 w && a != $past(a) ##1 r && a == $past(a, 2) |=> rdata == $past(req.wdata, 3);
	endproperty
	a_rst: assert property (p_rst) else $error("preset");
	a_frz: assert property (p_frz) else $error("freeze");
	a_wr: assert property (p_wr) else $error("write");
	a_old: assert property (p_old) else $error("old");
	a_rd: assert property (p_rd) else $error("read");
	a_keep: assert property (p_keep) else $error("keep");
	a_off: assert property (p_off) else $error("off");
	a_own: assert property (p_own) else $error("own");
	c_ww: cover property (w ##1 w);
	c_rst: cover property (clk_en && out_rst);
	c_off: cover property (!clk_en && req.we);
endmodule // spr_single_port_ram_assertions
bind spr_single_port_ram spr_single_port_ram_assertions CHK (.ref_clk(ref_clk),
	.reset(reset), .clk_en(clk_en), .out_rst(out_rst), .req(req), .rdata(rdata));
`default_nettype wire

// ---- single_port_ram_tb.sv ----
// Self-checking bench for the single-port RAM
`default_nettype none
module single_port_ram_tb
	import spr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic      ref_clk = 1'b0;
	logic      reset = 1'b1;
	logic      clk_en;
	logic      out_rst;
	spr_req_s  req;
	spr_word_t rdata;
	int        err_count = 0;
	int        n_compared = 0;
	// Fitted init list, zero beyond it
	spr_word_t init_exp [5] = '{16'h0100, 16'h0080, 16'hff40, 16'h7fff, 16'h0000};
`define CHK(e) begin n_compared++; if (rdata !== (e)) begin err_count++; \
	$display("Error %0t rdata %h exp %h", $time, rdata, e); end end
	spr_single_port_ram DUT (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
		.out_rst(out_rst), .req(req), .rdata(rdata));
	spr_drv DRV (.ref_clk(ref_clk), .clk_en(clk_en), .out_rst(out_rst), .req(req));
	initial forever #5 ref_clk = ~ref_clk;
	task complete_run;
		if (err_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task t_init;
		DRV.put(3'h4, 4'h0, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			DRV.put(3'h4, i[3:0], 16'h0000);
			if (i > 0)
				`CHK(init_exp[i-1])
		end
	endtask
	task t_wr;
		DRV.put(3'h5, 4'h5, 16'h1111);
		DRV.put(3'h5, 4'h5, 16'h2222);
		`CHK(16'h0000)
		DRV.put(3'h4, 4'h5, 16'h0000);
		`CHK(16'h1111)
		DRV.put(3'h4, 4'h5, 16'h0000);
		`CHK(16'h2222)
		DRV.put(3'h5, 4'h6, 16'h3333);
		`CHK(16'h2222)
		DRV.put(3'h5, 4'h7, 16'h4444);
		DRV.put(3'h4, 4'h6, 16'h0000);
		DRV.put(3'h4, 4'h7, 16'h0000);
		`CHK(16'h3333)
	endtask
	task t_rst;
		DRV.put(3'h5, 4'h8, 16'h5555);
		DRV.put(3'h6, 4'h8, 16'h0000);
		DRV.put(3'h4, 4'h8, 16'h0000);
		`CHK(16'h0000)
		DRV.put(3'h5, 4'h9, 16'h6666);
		`CHK(16'h5555)
		DRV.put(3'h1, 4'h9, 16'h9999);
		DRV.put(3'h4, 4'h9, 16'h0000);
		`CHK(16'h0000)
		DRV.put(3'h4, 4'h9, 16'h0000);
		`CHK(16'h6666)
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		#1;
		reset = 1'b0;
		t_init;
		t_wr;
		t_rst;
		complete_run;
	end
endmodule // single_port_ram_tb
`default_nettype wire
